// file: ingress_meter_params.svh
`ifndef INGRESS_METER_PARAMS_SVH
`define INGRESS_METER_PARAMS_SVH

// ==========================================
// register indices (byte address is index times four)
`define IRM_IDX_CFG 16'h184a
`define IRM_IDX_CMD 16'h184b
`define IRM_IDX_STS 16'h184c
`define IRM_IDX_WR 16'h184d
`define IRM_IDX_RD 16'h184e

// ==========================================
// field positions
`define IRM_CFG_EN_BIT 0
`define IRM_CFG_MODE_LSB 1
`define IRM_CFG_MODE_MSB 2
`define IRM_CMD_DIR_BIT 7
`define IRM_CMD_TYPE_MSB 6
`define IRM_CMD_TYPE_LSB 5
`define IRM_CMD_ADDR_MSB 4
`define IRM_CMD_ADDR_LSB 0
`define IRM_STS_PEND_BIT 0
`define IRM_DATA_MSB 15

// ==========================================
// encodings
`define IRM_MODE_PORT_PRIO 2'h0
`define IRM_MODE_PORT 2'h1
`define IRM_MODE_PRIO 2'h2
`define IRM_TYPE_RATE 2'h1
`define IRM_TYPE_CBS 2'h2
`define IRM_TYPE_EBS 2'h3
`define IRM_DIR_READ 1'b1

// ==========================================
// reset values
`define IRM_BURST_RST 16'h0600
`define IRM_RATE_RST 16'h0014
`define IRM_DATA_RST 16'h0000
`define IRM_CFG_RST 3'h0
`define IRM_CMD_RST 8'h00

// ==========================================
// timing and table size
`define IRM_RATE_STEP_NS 20
`define IRM_CLK_PERIOD_NS 20
`define IRM_CMD_LATENCY 2
`define IRM_NUM_ENTRIES 24

`endif

// file: ingress_meter_pkg.sv
`include "ingress_meter_params.svh"

package ingress_meter_pkg;

  typedef struct packed {
    logic [1:0] mode;
    logic enable;
  } meter_cfg_t;

  typedef struct packed {
    logic accessDirection;
    logic [1:0] kind;
    logic [4:0] addr;
  } meter_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] len;
    logic [1:0] port;
    logic [2:0] prio;
  } meter_pkt_t;

  typedef struct packed {
    logic valid;
    logic conform;
    logic randomDrop;
    logic drop;
  } meter_verdict_t;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CFG,
    SEL_CMD,
    SEL_STS,
    SEL_WR,
    SEL_RD
  } reg_sel_t;

  typedef enum logic [1:0] {
    CMD_IDLE,
    CMD_BUSY,
    CMD_FINISH
  } cmd_state_t;

endpackage

// file: meter_entry_select.sv
`timescale 1ns/1ps
`include "ingress_meter_params.svh"

// maps source port and priority, port only or priority only (per mode) onto a committed-rate entry; reserved mode gives entry 0
module meter_entry_select
  import ingress_meter_pkg::*;
(
  input wire logic [1:0] mode,
  input wire logic [1:0] port,
  input wire logic [2:0] prio,
  output logic [4:0] entry
);

  always_comb begin
    case (mode)
      `IRM_MODE_PORT_PRIO: entry = {port, prio};
      `IRM_MODE_PORT: entry = {3'h0, port};
      `IRM_MODE_PRIO: entry = {2'h0, prio};
      default: entry = 5'h00;
    endcase
  end

endmodule

// file: ingress_meter_config.sv
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "ingress_meter_params.svh"

module ingress_meter_config
  import ingress_meter_pkg::*;
#(
  parameter int NUM_ENTRIES = `IRM_NUM_ENTRIES,
  parameter int CMD_LATENCY = `IRM_CMD_LATENCY
)(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire meter_pkt_t pktIn,
  output meter_verdict_t verdict,
  output meter_cfg_t meterCfg,
  output logic [4:0] activeEntry
);

  localparam int STEP_CYC = (`IRM_RATE_STEP_NS + `IRM_CLK_PERIOD_NS - 1) / `IRM_CLK_PERIOD_NS;

  function automatic reg_sel_t decodeReg(input logic [15:0] a);
    reg_sel_t s;
    s = SEL_NONE;
    if (a == (`IRM_IDX_CFG << 2)) s = SEL_CFG;
    else if (a == (`IRM_IDX_CMD << 2)) s = SEL_CMD;
    else if (a == (`IRM_IDX_STS << 2)) s = SEL_STS;
    else if (a == (`IRM_IDX_WR << 2)) s = SEL_WR;
    else if (a == (`IRM_IDX_RD << 2)) s = SEL_RD;
    return s;
  endfunction

  // ==========================================
  // apb slave and direct registers
  meter_cfg_t cfg_q, cfg_d;
  meter_cmd_t cmd_q, cmd_d;
  logic [15:0] wrData_q, wrData_d;
  logic [31:0] prdata_q, prdata_d;
  logic slvErr_q, slvErr_d;
  logic pending_q;
  logic [15:0] rdData_q;
  logic setupPhase, accessWr, cmdWrite;
  reg_sel_t setupSel, accessSel;

  assign setupPhase = psel && !penable;
  assign setupSel = decodeReg(paddr);
  assign accessSel = decodeReg(paddr);
  assign accessWr = psel && penable && pwrite;
  assign cmdWrite = accessWr && accessSel == SEL_CMD;
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = slvErr_q && psel && penable;
  assign meterCfg = cfg_q;

  always_comb begin
    cfg_d = cfg_q;
    cmd_d = cmd_q;
    wrData_d = wrData_q;
    prdata_d = prdata_q;
    slvErr_d = slvErr_q;
    if (setupPhase) begin
      prdata_d = 32'h0;
      slvErr_d = setupSel == SEL_NONE;
      case (setupSel)
        SEL_CFG: prdata_d[`IRM_CFG_MODE_MSB:`IRM_CFG_EN_BIT] = cfg_q;
        SEL_CMD: prdata_d[`IRM_CMD_DIR_BIT:`IRM_CMD_ADDR_LSB] = cmd_q;
        SEL_STS: prdata_d[`IRM_STS_PEND_BIT] = pending_q;
        SEL_WR: prdata_d[`IRM_DATA_MSB:0] = wrData_q;
        SEL_RD: prdata_d[`IRM_DATA_MSB:0] = rdData_q;
        default: prdata_d = 32'h0;
      endcase
    end
    if (accessWr) begin
      case (accessSel)
        SEL_CFG: cfg_d = pwdata[`IRM_CFG_MODE_MSB:`IRM_CFG_EN_BIT];
        SEL_CMD: cmd_d = pwdata[`IRM_CMD_DIR_BIT:`IRM_CMD_ADDR_LSB];
        SEL_WR: wrData_d = pwdata[`IRM_DATA_MSB:0];
        default: wrData_d = wrData_q;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cfg_q <= `IRM_CFG_RST;
      cmd_q <= `IRM_CMD_RST;
      wrData_q <= `IRM_DATA_RST;
      prdata_q <= 32'h0;
      slvErr_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      cmd_q <= cmd_d;
      wrData_q <= wrData_d;
      prdata_q <= prdata_d;
      slvErr_q <= slvErr_d;
    end
  end

  // ==========================================
  // indirect table command engine
  cmd_state_t state_q, state_d;
  logic [7:0] wait_q, wait_d;
  logic pending_d;
  logic [15:0] rdData_d;
  logic [15:0] rate_q [NUM_ENTRIES];
  logic [15:0] rate_d [NUM_ENTRIES];
  logic [15:0] cbs_q, cbs_d, ebs_q, ebs_d;
  logic addrOk;

  assign addrOk = 32'(cmd_q.addr) < NUM_ENTRIES;

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    pending_d = pending_q;
    rdData_d = rdData_q;
    rate_d = rate_q;
    cbs_d = cbs_q;
    ebs_d = ebs_q;
    case (state_q)
      CMD_IDLE: wait_d = 8'h0;
      CMD_BUSY: begin
        wait_d = wait_q + 8'h1;
        if (32'(wait_q) + 1 >= CMD_LATENCY) state_d = CMD_FINISH;
      end
      CMD_FINISH: begin
        state_d = CMD_IDLE;
        pending_d = 1'b0;
        if (cmd_q.accessDirection == `IRM_DIR_READ) begin
          case (cmd_q.kind)
            `IRM_TYPE_RATE: rdData_d = addrOk ? rate_q[cmd_q.addr] : 16'h0;
            `IRM_TYPE_CBS: rdData_d = cbs_q;
            `IRM_TYPE_EBS: rdData_d = ebs_q;
            default: rdData_d = 16'h0;
          endcase
        end else begin
          case (cmd_q.kind)
            `IRM_TYPE_RATE: if (addrOk) rate_d[cmd_q.addr] = wrData_q;
            `IRM_TYPE_CBS: cbs_d = wrData_q;
            `IRM_TYPE_EBS: ebs_d = wrData_q;
            default: cbs_d = cbs_q;
          endcase
        end
      end
      default: state_d = CMD_IDLE;
    endcase
    // a new command restarts the engine and wins over completion
    if (cmdWrite) begin
      state_d = CMD_BUSY;
      wait_d = 8'h0;
      pending_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_q <= CMD_IDLE;
      wait_q <= 8'h0;
      pending_q <= 1'b0;
      rdData_q <= `IRM_DATA_RST;
      rate_q <= '{default: `IRM_RATE_RST};
      cbs_q <= `IRM_BURST_RST;
      ebs_q <= `IRM_BURST_RST;
    end else begin
      state_q <= state_d;
      wait_q <= wait_d;
      pending_q <= pending_d;
      rdData_q <= rdData_d;
      rate_q <= rate_d;
      cbs_q <= cbs_d;
      ebs_q <= ebs_d;
    end
  end

  // ==========================================
  // token buckets steered by the table
  logic [4:0] pktEntry;
  logic [4:0] entry_q, entry_d;
  logic [23:0] tick_q, tick_d, tickLimit;
  logic [15:0] cLevel_q, cLevel_d, eLevel_q, eLevel_d, curRate;
  meter_verdict_t verdict_q, verdict_d;

  meter_entry_select entrySel (
    .mode(cfg_q.mode),
    .port(pktIn.port),
    .prio(pktIn.prio),
    .entry(pktEntry)
  );

  assign curRate = (32'(entry_q) < NUM_ENTRIES) ? rate_q[entry_q] : `IRM_RATE_RST;
  assign tickLimit = 24'(({8'h0, curRate} + 24'h1) * 24'(STEP_CYC)) - 24'h1;
  assign verdict = verdict_q;
  assign activeEntry = entry_q;

  always_comb begin
    entry_d = entry_q;
    verdict_d = '0;
    tick_d = tick_q + 24'h1;
    cLevel_d = cLevel_q;
    eLevel_d = eLevel_q;
    // one byte token per rate period; no growth at or above the cap
    if (tick_q >= tickLimit) begin
      tick_d = 24'h0;
      if (cLevel_q < cbs_q) cLevel_d = cLevel_q + 16'h1;
      if (eLevel_q < ebs_q) eLevel_d = eLevel_q + 16'h1;
    end
    if (pktIn.valid && cfg_q.enable) begin
      entry_d = pktEntry;
      verdict_d.valid = 1'b1;
      if (pktIn.len <= cLevel_q) begin
        verdict_d.conform = 1'b1;
        cLevel_d = cLevel_q - pktIn.len;
      end else if (pktIn.len <= eLevel_q) begin
        verdict_d.randomDrop = 1'b1;
        eLevel_d = eLevel_q - pktIn.len;
      end else begin
        verdict_d.drop = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      entry_q <= 5'h0;
      tick_q <= 24'h0;
      cLevel_q <= `IRM_BURST_RST;
      eLevel_q <= `IRM_BURST_RST;
      verdict_q <= '0;
    end else begin
      entry_q <= entry_d;
      tick_q <= tick_d;
      cLevel_q <= cLevel_d;
      eLevel_q <= eLevel_d;
      verdict_q <= verdict_d;
    end
  end

  // ==========================================
  // checks
  // reset seen at the previous edge; unknown before the first edge keeps reset checks quiet
  logic rstSeen_q;

  always_ff @(posedge ref_clk) begin
    rstSeen_q <= srst;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  pend_set_a: assert property (cmdWrite |=> pending_q)
    else $error("pending not set after command write");
  pend_clear_a: assert property ($rose(pending_q) |-> pending_q[*2] ##[1:4] !pending_q)
    else $error("pending did not clear in time");
  rd_data_a: assert property ($fell(pending_q) && !$past(cmdWrite) && cmd_q.accessDirection
      && cmd_q.kind == `IRM_TYPE_CBS |-> rdData_q == cbs_q)
    else $error("read data differs from committed burst");
  rate_wr_a: assert property (state_q == CMD_FINISH && !cmdWrite && !cmd_q.accessDirection
      && cmd_q.kind == `IRM_TYPE_RATE && addrOk |=> rate_q[$past(cmd_q.addr)] == $past(wrData_q))
    else $error("rate entry not written");
  cbs_wr_a: assert property (state_q == CMD_FINISH && !cmdWrite && !cmd_q.accessDirection
      && cmd_q.kind == `IRM_TYPE_CBS |=> cbs_q == $past(wrData_q))
    else $error("committed burst not written");
  ebs_wr_a: assert property (state_q == CMD_FINISH && !cmdWrite && !cmd_q.accessDirection
      && cmd_q.kind == `IRM_TYPE_EBS |=> ebs_q == $past(wrData_q))
    else $error("excess burst not written");
  cfg_reset_a: assert property (disable iff (1'b0) rstSeen_q |-> cfg_q == `IRM_CFG_RST
      && cmd_q == `IRM_CMD_RST && !pending_q)
    else $error("config not reset");
  burst_reset_a: assert property (disable iff (1'b0) rstSeen_q |-> cbs_q == `IRM_BURST_RST
      && ebs_q == `IRM_BURST_RST && cLevel_q == `IRM_BURST_RST && rdData_q == `IRM_DATA_RST)
    else $error("burst state not reset");
  no_meter_a: assert property (!cfg_q.enable |=> !verdict_q.valid)
    else $error("verdict while metering disabled");
  conform_a: assert property (pktIn.valid && cfg_q.enable && pktIn.len <= cLevel_q
      |=> verdict_q.valid && verdict_q.conform && !verdict_q.drop)
    else $error("committed packet not conforming");
  random_drop_a: assert property (pktIn.valid && cfg_q.enable && pktIn.len > cLevel_q
      && pktIn.len <= eLevel_q |=> verdict_q.randomDrop && !verdict_q.drop)
    else $error("excess packet not marked for random drop");
  excess_drop_a: assert property (pktIn.valid && cfg_q.enable && pktIn.len > cLevel_q
      && pktIn.len > eLevel_q |=> verdict_q.drop && !verdict_q.conform)
    else $error("oversize burst not dropped");
  bucket_cap_a: assert property (cLevel_q >= cbs_q |=> cLevel_q <= $past(cLevel_q))
    else $error("bucket grew above cap");
  pair_map_a: assert property (pktIn.valid && cfg_q.enable && cfg_q.mode == `IRM_MODE_PORT_PRIO
      |=> entry_q == {$past(pktIn.port), $past(pktIn.prio)})
    else $error("port and priority entry mismatch");
  port_map_a: assert property (pktIn.valid && cfg_q.enable && cfg_q.mode == `IRM_MODE_PORT
      |=> entry_q == {3'h0, $past(pktIn.port)})
    else $error("port-only entry mismatch");
  prio_map_a: assert property (pktIn.valid && cfg_q.enable && cfg_q.mode == `IRM_MODE_PRIO
      |=> entry_q == {2'h0, $past(pktIn.prio)})
    else $error("priority-only entry mismatch");

  read_done_c: cover property ($fell(pending_q) && cmd_q.accessDirection);
  write_done_c: cover property ($fell(pending_q) && !cmd_q.accessDirection);
  drop_c: cover property (verdict_q.drop);
  random_c: cover property (verdict_q.randomDrop);
  reserved_cmd_c: cover property ($fell(pending_q) && cmd_q.kind == 2'h0);

endmodule

// file: ingress_meter_config_tb.sv
`timescale 1ns/1ps
`include "ingress_meter_params.svh"

module ingress_meter_config_tb
  import ingress_meter_pkg::*;
;
  // ==========================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  meter_pkt_t pktIn = '0;
  meter_verdict_t verdict;
  meter_cfg_t meterCfg;
  logic [4:0] activeEntry;
  int badCount = 0;
  int testsRun = 0;

  always #10 ref_clk = ~ref_clk;

  ingress_meter_config dut (
    .ref_clk(ref_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pktIn(pktIn), .verdict(verdict), .meterCfg(meterCfg), .activeEntry(activeEntry)
  );

  // ==========================================
  // shared helpers
  function automatic void chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    testsRun++;
    if (got !== expv) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", what, expv, got);
    end
  endfunction

  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait for the slave; only the watchdog ends a hung access
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic regWrite(input logic [15:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    xfer(1'b1, idx, wd, d, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask

  task automatic regRead(input string what, input logic [15:0] idx, input logic [31:0] expv);
    logic [31:0] d;
    logic e;
    xfer(1'b0, idx, 32'h0, d, e);
    chk(what, expv, d);
    chk("read error", 32'h0, {31'h0, e});
  endtask

  task automatic waitIdle();
    int n;
    logic [31:0] d;
    logic e;
    n = 0;
    do begin
      xfer(1'b0, `IRM_IDX_STS, 32'h0, d, e);
      n++;
    end while (d[0] !== 1'b0 && n < 20);
    chk("pending clear", 32'h0, {31'h0, d[0]});
    if (d[0] !== 1'b0) begin
      endOfTest();
    end
  endtask

  task automatic tableCmd(input logic dir, input logic [1:0] kind, input logic [4:0] addr,
                          input logic [15:0] wd);
    if (!dir) regWrite(`IRM_IDX_WR, {16'h0, wd});
    regWrite(`IRM_IDX_CMD, {24'h0, dir, kind, addr});
    waitIdle();
  endtask

  task automatic tableRead(input string what, input logic [1:0] kind, input logic [4:0] addr,
                           input logic [15:0] expv);
    tableCmd(1'b1, kind, addr, 16'h0);
    regRead(what, `IRM_IDX_RD, {16'h0, expv});
  endtask

  task automatic sendPkt(input logic [15:0] len, input logic [1:0] port, input logic [2:0] prio,
                         input logic [3:0] expv);
    @(posedge ref_clk);
    pktIn <= '{valid: 1'b1, len: len, port: port, prio: prio};
    @(posedge ref_clk);
    pktIn <= '0;
    @(posedge ref_clk);
    chk("verdict", {28'h0, expv}, {28'h0, verdict});
  endtask

  // ==========================================
  // scenarios
  task automatic testResetValues();
    regRead("config", `IRM_IDX_CFG, 32'h0);
    regRead("command", `IRM_IDX_CMD, 32'h0);
    regRead("status", `IRM_IDX_STS, 32'h0);
    regRead("write data", `IRM_IDX_WR, 32'h0);
    regRead("read data", `IRM_IDX_RD, 32'h0);
    tableRead("rate 0", 2'h1, 5'h00, 16'h0014);
    tableRead("rate 23", 2'h1, 5'h17, 16'h0014);
    tableRead("committed burst", 2'h2, 5'h00, 16'h0600);
    tableRead("excess burst", 2'h3, 5'h00, 16'h0600);
    regRead("command readback", `IRM_IDX_CMD, 32'he0);
  endtask

  task automatic testBurst();
    regWrite(`IRM_IDX_CFG, 32'h1);
    sendPkt(16'h0600, 2'h0, 3'h0, 4'hc);
    sendPkt(16'h0600, 2'h0, 3'h0, 4'ha);
    sendPkt(16'h0600, 2'h0, 3'h0, 4'h9);
  endtask

  task automatic testModes();
    logic [4:0] e;
    for (int m = 0; m < 3; m++) begin
      regWrite(`IRM_IDX_CFG, 32'hffff_fff8 | {29'h0, m[1:0], 1'b1});
      regRead("config mode", `IRM_IDX_CFG, {29'h0, m[1:0], 1'b1});
      chk("meter config", {29'h0, m[1:0], 1'b1}, {29'h0, meterCfg});
      for (int k = 0; k < 2; k++) begin
        e = (m == 0) ? {k[1:0] + 2'h1, 3'h5 + k[2:0] * 3'h2} : (m == 1) ? 5'(k + 1) : 5'(5 + 2 * k);
        sendPkt(16'h0000, 2'(k + 1), 3'(5 + 2 * k), 4'hc);
        chk("active entry", {27'h0, e}, {27'h0, activeEntry});
      end
    end
    regWrite(`IRM_IDX_CFG, 32'h7);
    sendPkt(16'h0000, 2'h2, 3'h3, 4'hc);
    chk("reserved mode entry", 32'h0, {27'h0, activeEntry});
    regWrite(`IRM_IDX_CFG, 32'h4);
    sendPkt(16'h0000, 2'h1, 3'h1, 4'h0);
    chk("meter config off", 32'h4, {29'h0, meterCfg});
  endtask

  task automatic testTable();
    logic [31:0] d;
    logic e;
    tableCmd(1'b0, 2'h1, 5'h17, 16'hbeef);
    regWrite(`IRM_IDX_WR, 32'h0000_1357);
    regWrite(`IRM_IDX_CMD, 32'h0000_0021);
    regRead("pending set", `IRM_IDX_STS, 32'h1);
    waitIdle();
    tableRead("rate 1", 2'h1, 5'h01, 16'h1357);
    tableRead("rate 23 written", 2'h1, 5'h17, 16'hbeef);
    tableCmd(1'b0, 2'h2, 5'h00, 16'h0123);
    tableCmd(1'b0, 2'h3, 5'h00, 16'h0456);
    tableRead("committed burst written", 2'h2, 5'h00, 16'h0123);
    tableRead("excess burst written", 2'h3, 5'h00, 16'h0456);
    regWrite(`IRM_IDX_WR, 32'hffff_abcd);
    regRead("write data width", `IRM_IDX_WR, 32'h0000_abcd);
    tableRead("reserved type", 2'h0, 5'h00, 16'h0000);
    regWrite(`IRM_IDX_RD, 32'h0000_ffff);
    regWrite(`IRM_IDX_STS, 32'h0000_0001);
    regRead("read data kept", `IRM_IDX_RD, 32'h0);
    regRead("status kept", `IRM_IDX_STS, 32'h0);
    xfer(1'b0, 16'h1849, 32'h0, d, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
  endtask

  task automatic testMidReset();
    regWrite(`IRM_IDX_CFG, 32'h5);
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    regRead("config after reset", `IRM_IDX_CFG, 32'h0);
    chk("meter config after reset", 32'h0, {29'h0, meterCfg});
    tableRead("rate 23 after reset", 2'h1, 5'h17, 16'h0014);
    tableRead("committed after reset", 2'h2, 5'h00, 16'h0600);
    tableRead("excess after reset", 2'h3, 5'h00, 16'h0600);
  endtask

  // ==========================================
  // run control
  task automatic endOfTest();
    if (badCount == 0 && testsRun > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    testResetValues();
    testBurst();
    testModes();
    testTable();
    testMidReset();
    endOfTest();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    badCount++;
    endOfTest();
  end
endmodule
